// [pkg/ahp_pkg.sv]
// Constants and carrier types for the converter host port
package ahp_pkg;
  localparam int DATA_W  = 10;
  localparam int IN_W    = 10;
  localparam int GAIN_W  = 3;
  localparam int PROD_W  = 16;
  localparam int STAGES  = 4;

  // Conversion range of the amplified value, in output steps
  localparam logic signed [PROD_W-1:0] VQ_ZS     = -16'sh0200;
  localparam logic signed [PROD_W-1:0] VQ_FS     = 16'sh01ff;
  localparam logic signed [PROD_W-1:0] VQ_OFFSET = 16'sh0200;
  localparam logic [DATA_W-1:0] CODE_MIN = 10'h000;
  localparam logic [DATA_W-1:0] CODE_MAX = 10'h3ff;
  localparam logic [DATA_W-1:0] MSB_FLIP = 10'h200;

  // Configuration word layout: select in [9:8], payload below
  localparam int SEL_HI = 9;
  localparam int SEL_LO = 8;
  localparam logic [1:0] SEL_CTRL    = 2'h0;
  localparam logic [1:0] SEL_DAC_LO  = 2'h2;
  localparam logic [1:0] SEL_DAC_HI  = 2'h3;
  localparam int BIT_TWOS    = 0;
  localparam int BIT_PWRDN   = 1;
  localparam int BIT_CLAMP   = 2;
  localparam int BIT_USE_DAC = 3;
  localparam int GAIN_LO     = 4;
  localparam int GAIN_HI     = 6;
  localparam int DAC_LO_W    = 8;
  localparam int DAC_HI_W    = 2;

  localparam logic [GAIN_W-1:0] GAIN_RST = 3'h1;
  localparam logic [DATA_W-1:0] DAC_RST  = 10'h200;

  typedef struct packed {
    logic              twos;
    logic              pwrdn;
    logic              clamp_en;
    logic              use_dac;
    logic [GAIN_W-1:0] gain;
    logic [DATA_W-1:0] dac_code;
  } ahp_cfg_type;

  typedef struct packed {
    logic              over;
    logic [DATA_W-1:0] code;
  } ahp_word_type;
endpackage

// [hdl/ahp_host_port.sv]
// Digital side of the pipelined converter with its shared host bus
`timescale 1ns/1ns

module ahp_host_port (
  // Clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  // Digitised analog inputs
  input  wire logic [ahp_pkg::IN_W-1:0]     analog_in_pos_i,
  input  wire logic [ahp_pkg::IN_W-1:0]     analog_in_neg_i,
  input  wire logic [ahp_pkg::DATA_W-1:0]   external_clamp_level_in_i,
  // Host control pins
  input  wire logic                         output_disable_i,
  input  wire logic                         write_strobe_i,
  // Shared data bus and its range flag
  input  wire logic [ahp_pkg::DATA_W-1:0]   shared_data_bus_i,
  output logic      [ahp_pkg::DATA_W-1:0]   shared_data_bus_o,
  output logic                              shared_data_bus_oe_o,
  output logic                              range_exceeded_flag_o,
  // Sample handshake
  output logic                              sample_valid_o,
  input  wire logic                         sample_ready_i,
  output logic                              pipe_ready_o,
  // Configuration seen by the analog side
  output logic [ahp_pkg::GAIN_W-1:0]        gain_o,
  output logic                              power_down_o,
  output logic                              clamp_enable_o,
  output logic [ahp_pkg::DATA_W-1:0]        clamp_buffer_out_o
);

  // Pin synchronisers, three deep
  logic [2:0]                  oe_sync;
  logic [2:0]                  wr_sync;
  logic [ahp_pkg::DATA_W-1:0]  bus_s1;
  logic [ahp_pkg::DATA_W-1:0]  bus_s2;
  logic [ahp_pkg::DATA_W-1:0]  bus_s3;
  logic                        oe_level;
  logic                        wr_level;
  logic [ahp_pkg::DATA_W-1:0]  wr_data;
  logic [2:0]                  next_oe_sync;
  logic [2:0]                  next_wr_sync;
  logic                        next_oe_level;
  logic                        next_wr_level;
  logic [ahp_pkg::DATA_W-1:0]  next_wr_data;
  logic                        wr_fall;

  always_comb begin
    next_oe_sync  = {oe_sync[1:0], output_disable_i};
    next_wr_sync  = {wr_sync[1:0], write_strobe_i};
    next_oe_level = oe_level;
    next_wr_level = wr_level;
    next_wr_data  = wr_data;
    wr_fall       = 1'b0;
    // A change counts only once stages two and three agree
    if (oe_sync[1] == oe_sync[2]) begin
      next_oe_level = oe_sync[2];
    end
    if (wr_sync[1] == wr_sync[2]) begin
      next_wr_level = wr_sync[2];
      wr_fall       = wr_level & ~wr_sync[2];
    end
    // Keep the word seen while the strobe was high; hold time is short
    if (wr_sync[1] & wr_sync[2]) begin
      next_wr_data = bus_s3;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_sync  <= 3'h7;
      wr_sync  <= 3'h0;
      bus_s1   <= '0;
      bus_s2   <= '0;
      bus_s3   <= '0;
      oe_level <= 1'b1;
      wr_level <= 1'b0;
      wr_data  <= '0;
    end else begin
      oe_sync  <= next_oe_sync;
      wr_sync  <= next_wr_sync;
      bus_s1   <= shared_data_bus_i;
      bus_s2   <= bus_s1;
      bus_s3   <= bus_s2;
      oe_level <= next_oe_level;
      wr_level <= next_wr_level;
      wr_data  <= next_wr_data;
    end
  end

  // Write-only configuration registers
  ahp_pkg::ahp_cfg_type cfg;
  ahp_pkg::ahp_cfg_type next_cfg;

  always_comb begin
    next_cfg = cfg;
    if (wr_fall) begin
      unique case (wr_data[ahp_pkg::SEL_HI:ahp_pkg::SEL_LO])
        ahp_pkg::SEL_CTRL: begin
          next_cfg.twos     = wr_data[ahp_pkg::BIT_TWOS];
          next_cfg.pwrdn    = wr_data[ahp_pkg::BIT_PWRDN];
          next_cfg.clamp_en = wr_data[ahp_pkg::BIT_CLAMP];
          next_cfg.use_dac  = wr_data[ahp_pkg::BIT_USE_DAC];
          next_cfg.gain =
            wr_data[ahp_pkg::GAIN_HI:ahp_pkg::GAIN_LO];
        end
        ahp_pkg::SEL_DAC_LO: begin
          next_cfg.dac_code[ahp_pkg::DAC_LO_W-1:0] =
            wr_data[ahp_pkg::DAC_LO_W-1:0];
        end
        ahp_pkg::SEL_DAC_HI: begin
          next_cfg.dac_code[ahp_pkg::DATA_W-1:ahp_pkg::DAC_LO_W] =
            wr_data[ahp_pkg::DAC_HI_W-1:0];
        end
        // Select 01 is unused; such a word changes nothing
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    // Reset leaves unity gain and a mid-scale clamp code
    if (!rst_n_i) begin
      cfg.twos     <= 1'b0;
      cfg.pwrdn    <= 1'b0;
      cfg.clamp_en <= 1'b0;
      cfg.use_dac  <= 1'b0;
      cfg.gain     <= ahp_pkg::GAIN_RST;
      cfg.dac_code <= ahp_pkg::DAC_RST;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Conversion pipeline: difference, gain, saturate, coding
  logic [ahp_pkg::STAGES-1:0]          vld;
  logic signed [ahp_pkg::IN_W:0]       diff;
  logic signed [ahp_pkg::PROD_W-1:0]   amp;
  ahp_pkg::ahp_word_type               sat;
  ahp_pkg::ahp_word_type               fmt;
  logic [ahp_pkg::STAGES-1:0]          next_vld;
  logic signed [ahp_pkg::IN_W:0]       next_diff;
  logic signed [ahp_pkg::PROD_W-1:0]   next_amp;
  ahp_pkg::ahp_word_type               next_sat;
  ahp_pkg::ahp_word_type               next_fmt;
  logic signed [ahp_pkg::PROD_W-1:0]   prod;
  logic signed [ahp_pkg::PROD_W-1:0]   biased;
  logic [ahp_pkg::GAIN_W:0]            gain_steps;
  logic                                advance;
  logic                                buf_in_ready;

  // A full buffer freezes the pipe so no word is overwritten
  assign advance = buf_in_ready;

  always_comb begin
    next_vld   = vld;
    next_diff  = diff;
    next_amp   = amp;
    next_sat   = sat;
    next_fmt   = fmt;
    gain_steps = {1'b0, cfg.gain} + {{ahp_pkg::GAIN_W{1'b0}}, 1'b1};
    // Difference times at most eight always fits the product width
    prod = ahp_pkg::PROD_W'(diff * $signed({1'b0, gain_steps}));
    biased = amp + ahp_pkg::VQ_OFFSET;
    if (advance) begin
      // Power-down stops new samples from entering
      next_vld  = {vld[ahp_pkg::STAGES-2:0], ~cfg.pwrdn};
      next_diff = $signed({1'b0, analog_in_pos_i})
                - $signed({1'b0, analog_in_neg_i});
      // Half-step gain units: (code + 1) / 2
      next_amp  = prod >>> 1;
      if (amp < ahp_pkg::VQ_ZS) begin
        next_sat.code = ahp_pkg::CODE_MIN;
        next_sat.over = 1'b1;
      end else if (amp > ahp_pkg::VQ_FS) begin
        next_sat.code = ahp_pkg::CODE_MAX;
        next_sat.over = 1'b1;
      end else begin
        next_sat.code = biased[ahp_pkg::DATA_W-1:0];
        next_sat.over = 1'b0;
      end
      next_fmt.over = sat.over;
      next_fmt.code = cfg.twos ? (sat.code ^ ahp_pkg::MSB_FLIP)
                               : sat.code;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vld  <= '0;
      diff <= '0;
      amp  <= '0;
      sat  <= '0;
      fmt  <= '0;
    end else begin
      vld  <= next_vld;
      diff <= next_diff;
      amp  <= next_amp;
      sat  <= next_sat;
      fmt  <= next_fmt;
    end
  end

  // Two-entry output buffer
  // Depth is fixed: the pointers are one bit wide
  localparam int BUF_DEPTH = 2;
  ahp_pkg::ahp_word_type  mem [2];
  ahp_pkg::ahp_word_type  next_mem [2];
  logic                   wr_ptr;
  logic                   rd_ptr;
  logic [1:0]             count;
  logic                   next_wr_ptr;
  logic                   next_rd_ptr;
  logic [1:0]             next_count;
  logic                   push;
  logic                   pop;

  assign buf_in_ready = (count != 2'h2);
  assign pipe_ready_o = buf_in_ready;
  // Push waits for a free slot even with a pop due; costs a cycle when full
  assign push = vld[ahp_pkg::STAGES-1] & buf_in_ready;
  assign pop  = (count != 2'h0) & sample_ready_i;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = fmt;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    unique case ({push, pop})
      2'b10:   next_count = count + 2'h1;
      2'b01:   next_count = count - 2'h1;
      default: next_count = count;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // One register per slot; a slot only changes when the pointer picks it
  for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_slot
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem[e] <= '0;
      end else begin
        mem[e] <= next_mem[e];
      end
    end
  end

  // Only sample words ever reach the bus; settings are never read back
  assign shared_data_bus_o     = mem[rd_ptr].code;
  assign range_exceeded_flag_o = mem[rd_ptr].over;
  assign shared_data_bus_oe_o  = ~oe_level;
  assign sample_valid_o        = (count != 2'h0);

  // Settings toward the analog side
  assign gain_o             = cfg.gain;
  assign power_down_o       = cfg.pwrdn;
  assign clamp_enable_o     = cfg.clamp_en;
  assign clamp_buffer_out_o = cfg.use_dac ? cfg.dac_code
                                          : external_clamp_level_in_i;

endmodule

// [dv/ahp_host_port_props.sv]
// Concurrent checks on the converter host port pins
`timescale 1ns/1ns
module ahp_host_port_props (
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  // Pins
  input wire logic [9:0] analog_in_pos_i,
  input wire logic [9:0] analog_in_neg_i,
  input wire logic       output_disable_i,
  input wire logic       write_strobe_i,
  input wire logic [9:0] shared_data_bus_o,
  input wire logic       shared_data_bus_oe_o,
  input wire logic       range_exceeded_flag_o,
  input wire logic       sample_valid_o,
  input wire logic       sample_ready_i,
  input wire logic       pipe_ready_o,
  input wire logic [2:0] gain_o,
  input wire logic       power_down_o,
  input wire logic       clamp_enable_o
);
  // Reset values cannot be checked with reset as the disable
  a_reset_values: assert property (
    @(posedge clock_i) !rst_n_i |-> gain_o == 3'h1 && !power_down_o
      && !shared_data_bus_oe_o && !sample_valid_o)
    else $error("reset values wrong");
  a_oe_release: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    output_disable_i [*5] |-> !shared_data_bus_oe_o)
    else $error("bus not released");
  a_oe_drive: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !output_disable_i [*5] |-> shared_data_bus_oe_o)
    else $error("bus not driven");
  a_flag_code: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    range_exceeded_flag_o |-> shared_data_bus_o inside
      {10'h000, 10'h3ff, 10'h200, 10'h1ff})
    else $error("flag without saturated code");
  a_head_hold: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    sample_valid_o && !sample_ready_i |=> sample_valid_o
      && $stable(shared_data_bus_o) && $stable(range_exceeded_flag_o))
    else $error("head word lost");
  // A full buffer with no taker stays full and keeps a head word
  a_full_valid: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !pipe_ready_o && !sample_ready_i |-> sample_valid_o ##1 !pipe_ready_o)
    else $error("full buffer lost a word");
  a_cfg_hold: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !write_strobe_i [*8] |-> $stable(gain_o) && $stable(power_down_o)
      && $stable(clamp_enable_o))
    else $error("config changed without write");
  // Zero difference held for six cycles must reach the bus five edges after it is applied
  a_zero_diff: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (analog_in_pos_i == analog_in_neg_i && sample_ready_i && pipe_ready_o
      && !power_down_o) [*6] |-> sample_valid_o && !range_exceeded_flag_o
      && shared_data_bus_o inside {10'h200, 10'h000})
    else $error("midscale code wrong");
endmodule

bind ahp_host_port ahp_host_port_props u_props (.*);

// [dv/ahp_host_model.sv]
// Host side model: sample sink and shared bus resolution
`timescale 1ns/1ns
module ahp_host_model (
  // Clock
  input  wire logic       clock_i,
  // Control from bench
  input  wire logic       stall_i,
  input  wire logic       host_drive_i,
  input  wire logic [9:0] host_word_i,
  // Device side
  input  wire logic       dev_oe_i,
  input  wire logic [9:0] dev_word_i,
  output logic            ready_o,
  output logic [9:0]      bus_level_o
);
  logic [9:0] last;
  // A slow host simply holds ready low
  assign ready_o = !stall_i;
  // Released bus shows no stale value: inverse of the last level
  assign bus_level_o = dev_oe_i ? dev_word_i :
                       (host_drive_i ? host_word_i : ~last);
  always_ff @(posedge clock_i) begin
    last <= bus_level_o;
  end
endmodule

// [dv/tb_top.sv]
// Self-checking bench of the converter host port
`timescale 1ns/1ns
module tb_top;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic [9:0] pos = 10'h100, neg = 10'h100, ext = 10'h155, hword = 10'h000;
  logic dis = 1'b0, wr = 1'b0, stall = 1'b0, hdrive = 1'b0;
  logic [9:0] bus_o, bus_lvl, clamp;
  logic oe, flag, valid, ready, pready, pdn, cen;
  logic [2:0] gain;
  int errors = 0, check_count = 0, cycles = 0;
  ahp_host_port dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .analog_in_pos_i(pos), .analog_in_neg_i(neg),
    .external_clamp_level_in_i(ext), .output_disable_i(dis),
    .write_strobe_i(wr), .shared_data_bus_i(bus_lvl),
    .shared_data_bus_o(bus_o), .shared_data_bus_oe_o(oe),
    .range_exceeded_flag_o(flag), .sample_valid_o(valid),
    .sample_ready_i(ready), .pipe_ready_o(pready), .gain_o(gain),
    .power_down_o(pdn), .clamp_enable_o(cen), .clamp_buffer_out_o(clamp));
  ahp_host_model host (.clock_i(clock_i), .stall_i(stall),
    .host_drive_i(hdrive), .host_word_i(hword), .dev_oe_i(oe),
    .dev_word_i(bus_o), .ready_o(ready), .bus_level_o(bus_lvl));
  // Fast clock keeps the run short; the host timing floor is relaxed
  initial forever #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr_cfg(input logic [9:0] w);
    @(negedge clock_i) dis = 1'b1;
    repeat (5) @(negedge clock_i);
    chk(oe, 0);
    hword = w;
    hdrive = 1'b1;
    @(negedge clock_i) wr = 1'b1;
    repeat (3) @(negedge clock_i);
    wr = 1'b0;
    repeat (5) @(negedge clock_i);
    hdrive = 1'b0;
    @(negedge clock_i) dis = 1'b0;
    repeat (12) @(negedge clock_i);
  endtask
  task automatic t_reset();
    chk(gain, 1);
    chk({pdn, cen, oe, valid}, 0);
    chk(clamp, ext);
  endtask
  task automatic t_latency();
    repeat (10) @(negedge clock_i);
    chk({flag, bus_o}, 10'h200);
    pos = 10'h164;
    repeat (4) @(negedge clock_i);
    chk(bus_o, 10'h200);
    @(negedge clock_i) chk(bus_o, 10'h264);
  endtask
  task automatic t_sat();
    pos = 10'h3ff;
    neg = 10'h000;
    repeat (8) @(negedge clock_i);
    chk({flag, bus_o}, 11'h7ff);
    pos = 10'h000;
    neg = 10'h3ff;
    repeat (8) @(negedge clock_i);
    chk({flag, bus_o}, 11'h400);
  endtask
  task automatic t_gain();
    pos = 10'h164;
    neg = 10'h100;
    for (int g = 0; g < 8; g++) begin
      wr_cfg({2'h0, 1'b0, 3'(g), 4'h0});
      chk(gain, g);
      chk({flag, bus_o}, 16'(512 + 50 * (g + 1)));
    end
    wr_cfg(10'h011);
    chk(bus_o, 10'h064);
  endtask
  task automatic t_dac();
    wr_cfg(10'h25a);
    wr_cfg(10'h303);
    wr_cfg(10'h01c);
    chk({cen, clamp}, 11'h75a);
    wr_cfg(10'h1ff);
    chk({cen, clamp}, 11'h75a);
    chk(gain, 1);
    wr_cfg(10'h010);
    chk({cen, clamp}, ext);
  endtask
  task automatic t_stall();
    logic [9:0] head;
    stall = 1'b1;
    repeat (8) @(negedge clock_i);
    head = bus_o;
    chk({pready, valid}, 1);
    pos = 10'h100;
    wr_cfg(10'h012);
    chk({pdn, bus_o}, {1'b1, head});
    stall = 1'b0;
    repeat (10) @(negedge clock_i);
    chk({valid, pready}, 1);
    wr_cfg(10'h010);
    repeat (8) @(negedge clock_i);
    chk({valid, bus_o}, 11'h600);
  endtask
  initial begin
    // A real falling edge, so every DUT flop is reset before the first edge; the host model's last is not
    #1 rst_n_i = 1'b0;
    repeat (16) @(negedge clock_i);
    t_reset();
    rst_n_i = 1'b1;
    t_latency();
    t_sat();
    t_gain();
    t_dac();
    t_stall();
    end_of_test();
  end
endmodule
